// ### snir_pkg.sv
// Package: register map, field layout, reset values and types for snir
package snir_pkg;

  // ------------------------------------------------------------------
  // Register offsets (pointer values)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CAL = 8'h15;
  localparam logic [7:0] OFS_NF1 = 8'h16;
  localparam logic [7:0] OFS_NF2 = 8'h17;
  localparam logic [7:0] OFS_NF3 = 8'h18;
  localparam logic [7:0] OFS_MAKER = 8'h1E;
  localparam logic [7:0] OFS_PART = 8'h1F;
  localparam logic [7:0] OFS_MAKER_ALIAS = 8'hFE;
  localparam logic [7:0] OFS_PART_ALIAS = 8'hFF;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int FLD_NF_LSB = 8;
  localparam int FLD_HYST_LSB = 0;
  localparam int FLD_ID_LSB = 8;
  localparam int FLD_CAL_MULT_LSB = 1;
  localparam int CAL_VOID_BIT = 0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RST_CAL = 16'h0000;
  localparam logic [7:0] RST_NF = 8'h00;
  localparam logic [7:0] RST_HYST = 8'h00;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } snir_state_e;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_PTR,
    PH_WMSB,
    PH_WLSB
  } snir_phase_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } snir_line_s;

endpackage

// ### snir_line_cond.sv
// Two-wire line event detector: start, stop and clock edges
`timescale 1ns/10ps
`default_nettype none
module snir_line_cond (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output snir_pkg::snir_line_s o_ev
);

  logic scl_q;
  logic sda_q;

  // Idle bus level is high, so both history flops reset high
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  assign o_ev.start = scl_q & i_scl & sda_q & ~i_sda;
  assign o_ev.stop = scl_q & i_scl & ~sda_q & i_sda;
  assign o_ev.scl_rise = ~scl_q & i_scl;
  assign o_ev.scl_fall = scl_q & ~i_scl;
  assign o_ev.sda = i_sda;

endmodule
`default_nettype wire

// ### snir_regs.sv
// Ideality, hysteresis, calibration and identity registers on two-wire bus
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RULE1] Calibration bit 0 always reads zero; writing one there does nothing.
// [RULE2] Register 16h holds channel one ideality factor in bits 15..8.
// [RULE3] Register 16h bits 7..0 hold binary hysteresis, 0.5 C per count.
// [RULE4] Register 17h holds channel two ideality factor in its upper byte.
// [RULE5] Register 18h exists only on the three-channel build, upper byte.
// [RULE6] Maker code sits in bits 15..8, readable at 1Eh and FEh.
// [RULE7] Part code sits in bits 15..8, readable at 1Fh and FFh.
// [RULE8] Calculations use calibration bits 15..1 only, never bit 0.
// [RULE9] Writes to identity registers or their aliases are ignored.
module snir_regs #(
  parameter int NUM_REMOTE = 3,
  parameter logic [6:0] DEV_ADDR = 7'h5C,
  // Arbitrary identity values
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] PART_CODE = 8'hA5
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  output logic [14:0] o_cal_multiplier,
  output logic [7:0] o_ideality_factor_1,
  output logic [7:0] o_ideality_factor_2,
  output logic [7:0] o_ideality_factor_3,
  output logic [7:0] o_temp_hysteresis
);

  if (!(NUM_REMOTE == 2 || NUM_REMOTE == 3)) begin : g_chk
    $error("NUM_REMOTE must be 2 or 3");
  end

  // ------------------------------------------------------------------
  // Register read decode
  // ------------------------------------------------------------------
  function automatic logic [15:0] read_word(input logic [7:0] ptr,
      input logic [15:0] cal, input logic [7:0] nf1, input logic [7:0] hy,
      input logic [7:0] nf2, input logic [7:0] nf3);
    logic [15:0] w;
    w = 16'h0000;
    if (ptr == snir_pkg::OFS_CAL) begin
      w = cal;
    end else if (ptr == snir_pkg::OFS_NF1) begin
      w = {nf1, hy};
    end else if (ptr == snir_pkg::OFS_NF2) begin
      w = {nf2, 8'h00};
    end else if (ptr == snir_pkg::OFS_NF3 && NUM_REMOTE == 3) begin
      w = {nf3, 8'h00};
    end else if (ptr == snir_pkg::OFS_MAKER ||
        ptr == snir_pkg::OFS_MAKER_ALIAS) begin
      w = {MAKER_CODE, 8'h00}; // [RULE6]
    end else if (ptr == snir_pkg::OFS_PART ||
        ptr == snir_pkg::OFS_PART_ALIAS) begin
      w = {PART_CODE, 8'h00}; // [RULE7]
    end
    return w;
  endfunction

  snir_pkg::snir_line_s ev;
  snir_pkg::snir_state_e state_q;
  snir_pkg::snir_phase_e phase_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] hold_q;
  logic [7:0] ptr_q;
  logic rd_q;
  logic lo_q;
  logic nack_q;
  logic [15:0] word_q;
  logic [7:0] tx_q;
  logic [15:0] cal_q;
  logic [7:0] nf1_q;
  logic [7:0] hyst_q;
  logic [7:0] nf2_q;
  logic [7:0] nf3_q;

  snir_line_cond u_line (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_ev(ev)
  );

  // ------------------------------------------------------------------
  // Byte framing decode
  // ------------------------------------------------------------------
  wire byte_done = (state_q == snir_pkg::ST_RX) && ev.scl_fall &&
      (cnt_q == 4'h8);
  wire addr_hit = (sh_q[7:1] == DEV_ADDR);
  wire reg_wr = byte_done && (phase_q == snir_pkg::PH_WLSB);
  wire [15:0] wr_data = {hold_q, sh_q};
  wire [15:0] rd_word = read_word(ptr_q, cal_q, nf1_q, hyst_q, nf2_q, nf3_q);
  wire tx_next = (state_q == snir_pkg::ST_TX_ACK) && ev.scl_fall && !nack_q;
  wire tx_first = (state_q == snir_pkg::ST_RX_ACK) && ev.scl_fall &&
      (phase_q == snir_pkg::PH_ADDR) && rd_q;

  assign o_sda = 1'b0;
  assign o_sda_oe = (state_q == snir_pkg::ST_RX_ACK) ||
      ((state_q == snir_pkg::ST_TX) && !tx_q[7]);

  // ------------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= snir_pkg::ST_IDLE;
      phase_q <= snir_pkg::PH_ADDR;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      hold_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_q <= 1'b0;
      lo_q <= 1'b0;
      nack_q <= 1'b0;
      word_q <= 16'h0000;
      tx_q <= 8'hFF;
    end else if (ev.start) begin
      state_q <= snir_pkg::ST_RX;
      phase_q <= snir_pkg::PH_ADDR;
      cnt_q <= 4'h0;
    end else if (ev.stop) begin
      state_q <= snir_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        snir_pkg::ST_IDLE: begin
          cnt_q <= 4'h0;
        end
        snir_pkg::ST_RX: begin
          if (ev.scl_rise) begin
            sh_q <= {sh_q[6:0], ev.sda};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            state_q <= snir_pkg::ST_RX_ACK;
            unique case (phase_q)
              snir_pkg::PH_ADDR: begin
                rd_q <= sh_q[0];
                if (!addr_hit) begin
                  state_q <= snir_pkg::ST_IDLE;
                end
              end
              snir_pkg::PH_PTR: ptr_q <= sh_q;
              snir_pkg::PH_WMSB: hold_q <= sh_q;
              snir_pkg::PH_WLSB: hold_q <= hold_q;
            endcase
          end
        end
        snir_pkg::ST_RX_ACK: begin
          if (ev.scl_fall) begin
            cnt_q <= 4'h0;
            if (tx_first) begin
              state_q <= snir_pkg::ST_TX;
              word_q <= rd_word;
              tx_q <= rd_word[15:8];
              lo_q <= 1'b0;
            end else begin
              state_q <= snir_pkg::ST_RX;
              unique case (phase_q)
                snir_pkg::PH_ADDR: phase_q <= snir_pkg::PH_PTR;
                snir_pkg::PH_PTR: phase_q <= snir_pkg::PH_WMSB;
                snir_pkg::PH_WMSB: phase_q <= snir_pkg::PH_WLSB;
                snir_pkg::PH_WLSB: phase_q <= snir_pkg::PH_WMSB;
              endcase
            end
          end
        end
        snir_pkg::ST_TX: begin
          if (ev.scl_fall) begin
            if (cnt_q == 4'h7) begin
              state_q <= snir_pkg::ST_TX_ACK;
              tx_q <= 8'hFF;
            end else begin
              tx_q <= {tx_q[6:0], 1'b1};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        snir_pkg::ST_TX_ACK: begin
          if (ev.scl_rise) begin
            nack_q <= ev.sda;
          end else if (ev.scl_fall) begin
            cnt_q <= 4'h0;
            // Host ack keeps streaming the same word, MSB then LSB
            if (tx_next) begin
              state_q <= snir_pkg::ST_TX;
              tx_q <= lo_q ? word_q[15:8] : word_q[7:0];
              lo_q <= ~lo_q;
            end else begin
              state_q <= snir_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Register bank
  // ------------------------------------------------------------------
  // Identity offsets fall through every branch, so writes there vanish
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cal_q <= snir_pkg::RST_CAL;
      nf1_q <= snir_pkg::RST_NF;
      hyst_q <= snir_pkg::RST_HYST;
      nf2_q <= snir_pkg::RST_NF;
      nf3_q <= snir_pkg::RST_NF;
    end else if (reg_wr) begin // [RULE9]
      if (ptr_q == snir_pkg::OFS_CAL) begin
        cal_q <= {wr_data[15:1], 1'b0}; // [RULE1]
      end
      if (ptr_q == snir_pkg::OFS_NF1) begin
        nf1_q <= wr_data[15:8]; // [RULE2]
        hyst_q <= wr_data[7:0]; // [RULE3]
      end
      if (ptr_q == snir_pkg::OFS_NF2) begin
        nf2_q <= wr_data[15:8]; // [RULE4]
      end
      if (ptr_q == snir_pkg::OFS_NF3 && NUM_REMOTE == 3) begin
        nf3_q <= wr_data[15:8]; // [RULE5]
      end
    end
  end

  assign o_cal_multiplier = cal_q[15:snir_pkg::FLD_CAL_MULT_LSB]; // [RULE8]
  assign o_ideality_factor_1 = nf1_q;
  assign o_temp_hysteresis = hyst_q;
  assign o_ideality_factor_2 = nf2_q;
  assign o_ideality_factor_3 = nf3_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  wire wr_id = reg_wr && (ptr_q == snir_pkg::OFS_MAKER ||
      ptr_q == snir_pkg::OFS_PART || ptr_q == snir_pkg::OFS_MAKER_ALIAS ||
      ptr_q == snir_pkg::OFS_PART_ALIAS);

  cal_void_bit_a: assert property ( // [RULE1]
    reg_wr && ptr_q == snir_pkg::OFS_CAL |=> cal_q[0] == 1'b0)
    else $error("calibration bit 0 not zero");
  cal_mult_a: assert property ( // [RULE8]
    reg_wr && ptr_q == snir_pkg::OFS_CAL |=>
      o_cal_multiplier == $past(wr_data[15:1]))
    else $error("multiplier does not follow written bits");
  nf1_write_a: assert property ( // [RULE2]
    reg_wr && ptr_q == snir_pkg::OFS_NF1 |=>
      o_ideality_factor_1 == $past(wr_data[15:8]))
    else $error("channel one factor not stored");
  hyst_write_a: assert property ( // [RULE3]
    reg_wr && ptr_q == snir_pkg::OFS_NF1 |=>
      o_temp_hysteresis == $past(wr_data[7:0]) && rd_word[7:0] ==
      o_temp_hysteresis)
    else $error("hysteresis not stored");
  nf2_write_a: assert property ( // [RULE4]
    reg_wr && ptr_q == snir_pkg::OFS_NF2 |=>
      o_ideality_factor_2 == $past(wr_data[15:8]))
    else $error("channel two factor not stored");
  nf3_absent_a: assert property ( // [RULE5]
    NUM_REMOTE == 2 |-> o_ideality_factor_3 == 8'h00)
    else $error("channel three present on two-channel build");
  maker_read_a: assert property ( // [RULE6]
    tx_first && (ptr_q == snir_pkg::OFS_MAKER ||
      ptr_q == snir_pkg::OFS_MAKER_ALIAS) |=>
      word_q == {MAKER_CODE, 8'h00})
    else $error("maker code not returned");
  part_read_a: assert property ( // [RULE7]
    tx_first && (ptr_q == snir_pkg::OFS_PART ||
      ptr_q == snir_pkg::OFS_PART_ALIAS) |=>
      word_q == {PART_CODE, 8'h00})
    else $error("part code not returned");
  id_write_ignored_a: assert property ( // [RULE9]
    wr_id |=> $stable(cal_q) && $stable(nf1_q) && $stable(hyst_q) &&
      $stable(nf2_q) && $stable(nf3_q))
    else $error("identity write changed a register");

endmodule
`default_nettype wire

// ### snir_host_model.sv
// Two-wire bus host model issuing register writes and reads
`timescale 1ns/10ps
`default_nettype none
module snir_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h5C
) (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_drv
);
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #10;
  endtask

  // Data moves only while clock is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_drv = b;
    tick(2);
    o_scl = 1'b1;
    tick(3);
    r = i_sda;
    o_scl = 1'b0;
    tick(2);
  endtask

  task automatic start_c();
    o_sda_drv = 1'b1;
    tick(1);
    o_scl = 1'b1;
    tick(3);
    o_sda_drv = 1'b0;
    tick(3);
    o_scl = 1'b0;
    tick(2);
  endtask

  task automatic stop_c();
    o_sda_drv = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(3);
    o_sda_drv = 1'b1;
    tick(3);
  endtask

  // Released line floats to the pull-up, so the ninth bit reads the ack
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask

  task automatic write_reg(input logic [7:0] p, input logic [15:0] d,
                           output logic ok);
    logic a0, a1, a2, a3;
    start_c();
    put_byte({DEV_ADDR, 1'b0}, a0);
    put_byte(p, a1);
    put_byte(d[15:8], a2);
    put_byte(d[7:0], a3);
    stop_c();
    ok = a0 & a1 & a2 & a3;
  endtask

  task automatic read_reg(input logic [7:0] p, output logic [15:0] d);
    logic a;
    start_c();
    put_byte({DEV_ADDR, 1'b0}, a);
    put_byte(p, a);
    start_c();
    put_byte({DEV_ADDR, 1'b1}, a);
    get_byte(1'b0, d[15:8]);
    get_byte(1'b1, d[7:0]);
    stop_c();
  endtask
endmodule
`default_nettype wire

// ### snir_regs_tb.sv
// Self-checking bench for ideality, hysteresis and identity registers
`timescale 1ns/10ps
`default_nettype none
module snir_regs_tb;
  localparam logic [7:0] MK = 8'h3C; // Arbitrary maker code
  localparam logic [7:0] PT = 8'hC3; // Arbitrary part code
  logic clk, nrst, scl, sda_drv, sda_oe, sda_out;
  logic [14:0] cal;
  logic [7:0] nf1, nf2, nf3, hy;
  // Open-drain wire: pulled up unless the host drives low or the device enables its low drive
  wire logic sda_w = sda_drv & (sda_oe ? sda_out : 1'b1);
  logic scl2, sda_drv2, sda_oe2, sda_out2;
  logic [7:0] nf2b, nf3b;
  wire logic sda_w2 = sda_drv2 & (sda_oe2 ? sda_out2 : 1'b1);
  int errors = 0;
  int tests_run = 0;

  snir_regs #(.NUM_REMOTE(3), .DEV_ADDR(7'h5C), .MAKER_CODE(MK),
    .PART_CODE(PT)) dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_scl(scl),
    .i_sda(sda_w), .o_sda(sda_out), .o_sda_oe(sda_oe),
    .o_cal_multiplier(cal), .o_ideality_factor_1(nf1),
    .o_ideality_factor_2(nf2), .o_ideality_factor_3(nf3),
    .o_temp_hysteresis(hy));

  snir_host_model #(.DEV_ADDR(7'h5C)) host_u (.i_ref_clk(clk),
    .i_sda(sda_w), .o_scl(scl), .o_sda_drv(sda_drv));

  // Two-channel build on a bus of its own
  snir_regs #(.NUM_REMOTE(2), .DEV_ADDR(7'h5C), .MAKER_CODE(MK),
    .PART_CODE(PT)) dut2_u (.i_ref_clk(clk), .i_nrst(nrst), .i_scl(scl2),
    .i_sda(sda_w2), .o_sda(sda_out2), .o_sda_oe(sda_oe2),
    .o_cal_multiplier(), .o_ideality_factor_1(),
    .o_ideality_factor_2(nf2b), .o_ideality_factor_3(nf3b),
    .o_temp_hysteresis());

  snir_host_model #(.DEV_ADDR(7'h5C)) host2_u (.i_ref_clk(clk),
    .i_sda(sda_w2), .o_scl(scl2), .o_sda_drv(sda_drv2));

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  task automatic final_report();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Write, check ack, read back
  task automatic wr_rd(input string nm, input logic [7:0] p,
                       input logic [15:0] w, input logic [15:0] e);
    logic ok;
    logic [15:0] d;
    host_u.write_reg(p, w, ok);
    chk({nm, "_ack"}, 16'h0001, {15'h0000, ok});
    host_u.read_reg(p, d);
    chk(nm, e, d);
  endtask

  task automatic t_reset();
    chk("reset_ports", 16'h0000, {1'b0, cal} | {nf1, hy} | {nf2, nf3});
    chk("reset_oe", 16'h0000, {15'h0000, sda_oe});
    chk("reset_sda", 16'h0000, {15'h0000, sda_out});
    chk("reset_two", 16'h0000, {nf2b, nf3b} | {15'h0000, sda_oe2});
  endtask

  task automatic t_nf1();
    wr_rd("nf1_full", snir_pkg::OFS_NF1, 16'h3CFF, 16'h3CFF);
    chk("nf1_port", 16'h3CFF, {nf1, hy});
    wr_rd("nf1_low", snir_pkg::OFS_NF1, 16'hC300, 16'hC300);
    chk("nf1_port2", 16'hC300, {nf1, hy});
  endtask

  task automatic t_nf23();
    wr_rd("nf2", snir_pkg::OFS_NF2, 16'h1234, 16'h1200);
    chk("nf2_port", 16'h0012, {8'h00, nf2});
    wr_rd("nf3", snir_pkg::OFS_NF3, 16'h9A56, 16'h9A00);
    chk("nf3_port", 16'h9A12, {nf3, nf2});
    chk("nf1_kept", 16'hC300, {nf1, hy});
  endtask

  task automatic t_cal();
    wr_rd("cal_ones", snir_pkg::OFS_CAL, 16'hFFFF, 16'hFFFE);
    chk("cal_mult1", 16'h7FFF, {1'b0, cal});
    wr_rd("cal_edge", snir_pkg::OFS_CAL, 16'h8003, 16'h8002);
    chk("cal_mult2", 16'h4001, {1'b0, cal});
  endtask

  // Identity places and one unmapped offset; writes must not stick
  task automatic t_ids();
    logic [7:0] pa [5] = '{8'h1E, 8'hFE, 8'h1F, 8'hFF, 8'h20};
    logic [7:0] ea [5] = '{MK, MK, PT, PT, 8'h00};
    logic [15:0] d;
    for (int i = 0; i < 5; i++) begin
      host_u.read_reg(pa[i], d);
      chk("id_read", {ea[i], 8'h00}, d);
      wr_rd("id_after_wr", pa[i], 16'hFFFF, {ea[i], 8'h00});
    end
  endtask

  // Host acks the low byte, so the high byte comes round again
  task automatic t_stream();
    logic a;
    logic [7:0] b0, b1, b2;
    host_u.start_c();
    host_u.put_byte({7'h5C, 1'b0}, a);
    host_u.put_byte(snir_pkg::OFS_NF1, a);
    host_u.start_c();
    host_u.put_byte({7'h5C, 1'b1}, a);
    host_u.get_byte(1'b0, b0);
    host_u.get_byte(1'b0, b1);
    host_u.get_byte(1'b1, b2);
    host_u.stop_c();
    chk("stream_hi", 16'hC3C3, {b0, b2});
    chk("stream_lo", 16'h0000, {8'h00, b1});
  endtask

  // Two words in one frame, then a frame for some other address
  task automatic t_burst();
    logic a0, a1, a2, a3;
    host_u.start_c();
    host_u.put_byte({7'h5C, 1'b0}, a0);
    host_u.put_byte(snir_pkg::OFS_NF2, a1);
    host_u.put_byte(8'h11, a2);
    host_u.put_byte(8'h22, a3);
    chk("burst_w1", 16'h0011, {8'h00, nf2});
    host_u.put_byte(8'h33, a2);
    host_u.put_byte(8'h44, a3);
    host_u.stop_c();
    chk("burst_w2", 16'h0033, {8'h00, nf2});
    host_u.start_c();
    host_u.put_byte({7'h5D, 1'b0}, a0);
    host_u.put_byte(snir_pkg::OFS_NF2, a1);
    host_u.put_byte(8'h77, a2);
    host_u.put_byte(8'h77, a3);
    host_u.stop_c();
    chk("foreign_ack", 16'h0000, {15'h0000, a0});
    chk("foreign_nf2", 16'h0033, {8'h00, nf2});
  endtask

  // Two-channel build: third factor absent, writes there vanish
  task automatic t_two();
    logic ok;
    logic [15:0] d;
    host2_u.write_reg(snir_pkg::OFS_NF3, 16'h9A56, ok);
    chk("two_nf3_ack", 16'h0001, {15'h0000, ok});
    host2_u.read_reg(snir_pkg::OFS_NF3, d);
    chk("two_nf3_read", 16'h0000, d);
    host2_u.write_reg(snir_pkg::OFS_NF2, 16'h5A5A, ok);
    chk("two_ports", 16'h5A00, {nf2b, nf3b});
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #5000000;
    errors++;
    final_report();
  end

  initial begin
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #10;
    nrst = 1'b1;
    @(posedge clk);
    #10;
    t_reset();
    t_nf1();
    t_nf23();
    t_stream();
    t_burst();
    t_cal();
    t_ids();
    t_two();
    final_report();
  end
endmodule
`default_nettype wire
